// *** rtl/flash_front.sv ***
// pin front end of a serial flash: select, lane sampling and driving, pause, reset
// assumes the host drives sclk_i in mode 0 or 3 and software polls the register port
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_defs.svh"
module flash_front
  import flash_front_pkg::*;
#(
  parameter int SECTORS   = 16384,
  parameter int SECTOR_AW = 14
)(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 we_i,
  input  wire logic                 re_i,
  output logic      [31:0]          rdata_o,
  input  wire logic                 busy_i,
  input  wire logic                 sclk_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 reset_n_i,
  input  wire logic [3:0]           lane_in_i,
  output logic      [3:0]           lane_out_o,
  output logic      [3:0]           lane_oe_o,
  output logic                      quad_lane_enable_o,
  output logic                      status_write_block_o,
  output logic                      prot_none_o,
  output logic      [SECTOR_AW-1:0] prot_first_o,
  output logic      [SECTOR_AW-1:0] prot_last_o
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (SECTORS != (1 << SECTOR_AW) || SECTOR_AW < 14)
  begin : g_bad_size
    $error("flash_front: SECTORS must be 2**SECTOR_AW with SECTOR_AW >= 14");
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  // quad request without the enable falls back to one lane
  function automatic lanes_t eff_lanes(input lanes_t req, input logic qe);
    lanes_t r;
    r = req;
    if (req == LANE_X4 && !qe)
      r = LANE_X1; // [R7]
    if (req != LANE_X1 && req != LANE_X2 && req != LANE_X4)
      r = LANE_X1;
    return r;
  endfunction : eff_lanes

  // bits moved per clock edge for a lane configuration
  function automatic logic [3:0] lane_bits(input lanes_t l);
    logic [3:0] b;
    case (l)
      LANE_X2: b = 4'h2;
      LANE_X4: b = 4'h4;
      default: b = 4'h1;
    endcase
    return b;
  endfunction : lane_bits

  // ==========================================================================
  // configuration and pin roles
  // ==========================================================================
  cfg_t        cfg_q;
  mode_t       mode_q;
  logic [7:0]  tx_hold_q;
  logic        tx_req_q;

  // cfg and mode are quasi-static: software changes them only while deselected,
  // so the link logic reads them without a synchroniser
  wire qe        = cfg_q.quad_lane_enable;
  wire pause_pin = ~qe & ~cfg_q.lane3_reset_sel & ~lane_in_i[3]; // [R12] [R14]
  wire l3_reset  = ~qe &  cfg_q.lane3_reset_sel & ~lane_in_i[3]; // [R12] [R14]
  wire pin_rst   = ~reset_n_i | l3_reset;    // [R13] pulled-up pin idles inactive
  wire link_rst  = cs_n_i | pin_rst;         // [R1] [R17] [R18]

  // ==========================================================================
  // link side: receive on rising sclk
  // ==========================================================================
  logic [7:0]  rx_sh_q;
  logic [2:0]  rx_cnt_q;
  logic        instr_done_q;
  logic [7:0]  rx_buf_q;
  logic        rx_buf_first_q;
  logic        rx_tog_q;
  logic [7:0]  rx_next;

  // instruction byte is always one lane, later phases as configured
  wire lanes_t rx_lanes = instr_done_q ? eff_lanes(mode_q.rx_lanes, qe) : LANE_X1;
  wire [3:0]   rx_sum   = {1'b0, rx_cnt_q} + lane_bits(rx_lanes);
  wire         rx_byte  = rx_sum[3];

  // shift in from the lanes in use
  always_comb
  begin
    case (rx_lanes)
      LANE_X2: rx_next = {rx_sh_q[5:0], lane_in_i[1:0]};  // [R6]
      LANE_X4: rx_next = {rx_sh_q[3:0], lane_in_i[3:0]};  // [R6] [R7]
      default: rx_next = {rx_sh_q[6:0], lane_in_i[0]};    // [R4]
    endcase
  end

  // shifter, cleared by deselect; a paused clock leaves it untouched
  always_ff @(posedge sclk_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      rx_sh_q      <= 8'h00; // [R18]
      rx_cnt_q     <= 3'h0;
      instr_done_q <= 1'b0;
    end
    else if (!pause_pin) // [R10] [R11] [R16]
    begin
      rx_sh_q  <= rx_next; // [R4] [R6] [R15]
      rx_cnt_q <= rx_sum[2:0];
      if (rx_byte)
        instr_done_q <= 1'b1;
    end
  end

  // byte handoff; toggle survives deselect so the far side sees no false edge
  always_ff @(posedge sclk_i or posedge pin_rst)
  begin
    if (pin_rst)
    begin
      rx_buf_q       <= 8'h00;
      rx_buf_first_q <= 1'b0;
      rx_tog_q       <= 1'b0;
    end
    else if (!cs_n_i && !pause_pin && rx_byte)
    begin
      rx_buf_q       <= rx_next;
      rx_buf_first_q <= ~instr_done_q;
      rx_tog_q       <= ~rx_tog_q;
    end
  end

  // ==========================================================================
  // link side: transmit on falling sclk
  // ==========================================================================
  logic [7:0]  tx_sh_q;
  logic [2:0]  tx_cnt_q;
  logic [1:0]  req_s_q;
  logic        req_seen_q;
  logic [3:0]  out_d;
  logic [3:0]  oe_mask;

  wire lanes_t tx_lanes = eff_lanes(mode_q.tx_lanes, qe);
  wire [3:0]   tx_sum   = {1'b0, tx_cnt_q} + lane_bits(tx_lanes);
  wire         tx_load  = (tx_cnt_q == 3'h0);
  wire [7:0]   tx_src   = tx_load ? tx_hold_q : tx_sh_q;
  wire         tx_new   = req_s_q[1] ^ req_seen_q;
  // pause sampled raw: the falling edge itself ends the old hold phase
  wire         drive    = mode_q.tx_drive & instr_done_q & ~pause_pin; // [R10] [R16]
  wire [7:0]   tx_rest  = tx_src << lane_bits(tx_lanes);

  // top bits of the byte go to the lanes in use
  always_comb
  begin
    case (tx_lanes)
      LANE_X2:
      begin
        out_d   = {2'b00, tx_src[7:6]};   // [R6]
        oe_mask = 4'h3;
      end
      LANE_X4:
      begin
        out_d   = tx_src[7:4];            // [R6] [R7]
        oe_mask = 4'hf;
      end
      default:
      begin
        out_d   = {2'b00, tx_src[7], 1'b0}; // [R5] serial output is lane 1
        oe_mask = 4'h2;
      end
    endcase
  end

  // pin drivers float at once on deselect
  always_ff @(negedge sclk_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      lane_out_o <= 4'h0;
      lane_oe_o  <= 4'h0; // [R1]
      tx_sh_q    <= 8'h00;
      tx_cnt_q   <= 3'h0;
    end
    else
    begin
      lane_oe_o <= drive ? oe_mask : 4'h0; // [R5] [R6] [R10]
      if (drive)
      begin
        lane_out_o <= out_d;
        tx_sh_q    <= tx_rest;
        tx_cnt_q   <= tx_sum[2:0];
      end
    end
  end

  // request toggle from the register side, acknowledged at each byte load
  always_ff @(negedge sclk_i or posedge pin_rst)
  begin
    if (pin_rst)
    begin
      req_s_q    <= 2'b00;
      req_seen_q <= 1'b0;
    end
    else
    begin
      req_s_q <= {req_s_q[0], tx_req_q};
      if (drive && tx_load && tx_new)
        req_seen_q <= req_s_q[1];
    end
  end

  // ==========================================================================
  // register side: synchronisers
  // ==========================================================================
  logic [1:0]  cs_s_q;
  logic [1:0]  hrst_s_q;
  logic [1:0]  wp_s_q;
  logic [1:0]  pause_s_q;
  logic [2:0]  rxt_s_q;
  logic [1:0]  ack_s_q;

  // every pin and link control signal passes two flops before use; the received byte is taken directly on its toggle
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_s_q    <= 2'b00; // reset must not pass for select seen high [R3]
      hrst_s_q  <= 2'b00;
      wp_s_q    <= 2'b11;
      pause_s_q <= 2'b00;
      rxt_s_q   <= 3'b000;
      ack_s_q   <= 2'b00;
    end
    else
    begin
      cs_s_q    <= {cs_s_q[0], cs_n_i};
      hrst_s_q  <= {hrst_s_q[0], pin_rst};
      wp_s_q    <= {wp_s_q[0], lane_in_i[2]};
      pause_s_q <= {pause_s_q[0], pause_pin & ~cs_n_i};
      rxt_s_q   <= {rxt_s_q[1:0], rx_tog_q};
      ack_s_q   <= {ack_s_q[0], req_seen_q};
    end
  end

  wire hw_rst  = hrst_s_q[1];
  wire rx_evt  = rxt_s_q[2] ^ rxt_s_q[1];
  wire tx_pend = tx_req_q ^ ack_s_q[1];

  // ==========================================================================
  // register side: select arming and receive
  // ==========================================================================
  logic        seen_high_q;
  logic        armed_q;
  logic [7:0]  rx_data_q;
  logic        rx_first_q;
  logic        rx_full_q;
  logic        ovr_q;
  logic        qref_q;

  wire wr_cfg  = we_i && addr_i == `REG_CONFIG;
  wire wr_mode = we_i && addr_i == `REG_MODE;
  wire wr_tx   = we_i && addr_i == `REG_TXDATA;
  wire wr_st   = we_i && addr_i == `REG_STATUS;
  wire rd_rx   = re_i && addr_i == `REG_RXDATA;
  wire rx_take = rx_evt & armed_q; // [R3]
  wire mode_q4 = wdata_i[1:0] == LANE_X4 || wdata_i[3:2] == LANE_X4;

  // arm only after a high-to-low select seen since reset
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seen_high_q <= 1'b0;
      armed_q     <= 1'b0;
    end
    else if (hw_rst)
    begin
      seen_high_q <= 1'b0; // [R18]
      armed_q     <= 1'b0;
    end
    else
    begin
      if (cs_s_q[1])
        seen_high_q <= 1'b1;
      if (!cs_s_q[1] && seen_high_q)
        armed_q <= 1'b1; // [R3]
    end
  end

  // received byte holding; a new byte wins over a read that empties it
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_data_q  <= 8'h00;
      rx_first_q <= 1'b0;
      rx_full_q  <= 1'b0;
      ovr_q      <= 1'b0;
      qref_q     <= 1'b0;
    end
    else if (hw_rst)
    begin
      rx_full_q <= 1'b0; // [R18]
    end
    else
    begin
      if (rx_take)
      begin
        rx_data_q  <= rx_buf_q;
        rx_first_q <= rx_buf_first_q;
      end
      rx_full_q <= rx_take | (rx_full_q & ~rd_rx);
      // sticky flags: set beats write-one-to-clear
      ovr_q  <= (rx_take & rx_full_q & ~rd_rx) | (ovr_q & ~(wr_st & wdata_i[`ST_OVERRUN]));
      qref_q <= (wr_mode & mode_q4 & ~qe) | (qref_q & ~(wr_st & wdata_i[`ST_QUAD_REF]));
    end
  end

  // ==========================================================================
  // register side: configuration, mode and transmit word
  // ==========================================================================
  // transmit word is refused while the previous one is not yet taken
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_q     <= cfg_t'(`CFG_RESET);
      mode_q    <= mode_t'(`MODE_RESET);
      tx_hold_q <= 8'h00;
      tx_req_q  <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= cfg_t'(wdata_i[`CFG_WIDTH-1:0]);
      if (wr_mode)
        mode_q <= mode_t'(wdata_i[`MODE_WIDTH-1:0]);
      if (wr_tx && !tx_pend)
      begin
        tx_hold_q <= wdata_i[7:0];
        tx_req_q  <= ~tx_req_q;
      end
    end
  end

  // ==========================================================================
  // protection range and status
  // ==========================================================================
  localparam logic [SECTOR_AW:0] NSEC = (SECTOR_AW+1)'(SECTORS);
  wire [3:0]           bp      = cfg_q.block_protect;
  // no sectors at setting 0, one sector at setting 1, doubling up to 2**14 sectors at setting 15, the whole array only when SECTOR_AW is 14
  wire [SECTOR_AW:0]   psize   = (bp == 4'h0) ? '0 : (SECTOR_AW+1)'(1) << (bp - 4'h1); // [R9]
  wire [SECTOR_AW:0]   top_lo  = NSEC - psize;
  wire                 bottom  = cfg_q.protect_top_bottom;
  wire                 cmp     = cfg_q.protect_complement;
  wire                 p_none  = cmp ? (psize == NSEC) : (psize == '0);
  wire [SECTOR_AW:0]   p_first = (bottom ^ cmp) ? '0 : (cmp ? psize : top_lo); // [R9]
  wire [SECTOR_AW:0]   p_last  = (bottom ^ cmp) ? (cmp ? top_lo : psize) - 1'b1 : NSEC - 1'b1;
  // write-protect pin only counts while it is not a data lane
  wire                 sr_blk  = cfg_q.status_lock_mode & ~wp_s_q[1] & ~qe; // [R8]

  // status word; busy is passed through untouched by deselect
  wire [31:0] status_w = {22'h0,
                          tx_pend,
                          ~cs_s_q[1],
                          sr_blk,
                          pause_s_q[1],
                          busy_i,      // [R2]
                          qref_q,
                          ovr_q,
                          rx_first_q,
                          rx_full_q,
                          armed_q};

  // read selection; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    case (addr_i)
      `REG_CONFIG: rd_mux = {{(32-`CFG_WIDTH){1'b0}}, cfg_q};
      `REG_MODE:   rd_mux = {{(32-`MODE_WIDTH){1'b0}}, mode_q};
      `REG_TXDATA: rd_mux = {24'h0, tx_hold_q};
      `REG_RXDATA: rd_mux = {24'h0, rx_data_q};
      `REG_STATUS: rd_mux = status_w;
      `REG_PROT:   rd_mux = 32'(p_last[SECTOR_AW-1:0]) << `PROT_LAST_LSB
                          | 32'(p_first[SECTOR_AW-1:0]);
      default:     rd_mux = 32'h0;
    endcase
  end

  // registered outputs
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o              <= 32'h0;
      quad_lane_enable_o   <= 1'b0;
      status_write_block_o <= 1'b0;
      prot_none_o          <= 1'b1;
      prot_first_o         <= '0;
      prot_last_o          <= '0;
    end
    else
    begin
      rdata_o              <= re_i ? rd_mux : 32'h0;
      quad_lane_enable_o   <= qe;
      status_write_block_o <= sr_blk; // [R8]
      prot_none_o          <= p_none;
      prot_first_o         <= p_first[SECTOR_AW-1:0];
      prot_last_o          <= p_last[SECTOR_AW-1:0];
    end
  end

endmodule : flash_front
`default_nettype wire

// *** rtl/flash_front_defs.svh ***
// register offsets, field positions and reset values of the flash pin front end
// assumes a 32-bit plain register port with byte addresses, one word per register
// Operation
// R1 - select high floats every data lane
// R2 - running internal cycle survives deselect
// R3 - ignore instructions until first select fall
// R4 - single lane samples serial input on rise
// R5 - single lane drives serial output on fall
// R6 - dual/quad sample on rise, drive on fall
// R7 - quad only with quad_lane_enable; lanes 2,3
// R8 - write-protect pin blocks status writes
// R9 - protection covers one sector to array; code stops at 2**14 sectors, whole array only when SECTOR_AW is 14
// R10 - pause floats output, ignores clock, keeps state
// R11 - pause release resumes where it stopped
// R12 - pause/reset pin inactive while carrying quad
// R13 - dedicated reset pin resets regardless; floats ok
// R14 - lane 3 pause or reset, neither in quad
// R15 - clock modes 0 and 3 supported
// R16 - pause acts on clock low or next fall
// R17 - host holds select low during pause
// R18 - reset aborts shifting, back to idle
`ifndef FLASH_FRONT_DEFS_SVH
`define FLASH_FRONT_DEFS_SVH
`define REG_CONFIG   8'h00
`define REG_MODE     8'h04
`define REG_TXDATA   8'h08
`define REG_RXDATA   8'h0c
`define REG_STATUS   8'h10
`define REG_PROT     8'h14
`define CFG_WIDTH    9
`define CFG_RESET    9'h000
`define MODE_WIDTH   5
`define MODE_RESET   5'h00
`define ST_ARMED     0
`define ST_RX_FULL   1
`define ST_RX_FIRST  2
`define ST_OVERRUN   3
`define ST_QUAD_REF  4
`define ST_BUSY      5
`define ST_PAUSE     6
`define ST_SR_BLOCK  7
`define ST_SELECTED  8
`define ST_TX_PEND   9
`define PROT_LAST_LSB 16
`endif

// *** rtl/flash_front_pkg.sv ***
// types shared by the flash pin front end
// assumes flash_front_defs.svh for offsets and field positions
package flash_front_pkg;
  // lane configuration of a transfer phase
  typedef enum logic [1:0] {
    LANE_X1 = 2'h0,
    LANE_X2 = 2'h1,
    LANE_X4 = 2'h2
  } lanes_t;
  // configuration word, bit 0 first from the right
  typedef struct packed {
    logic [3:0] block_protect;
    logic       protect_complement;
    logic       protect_top_bottom;
    logic       status_lock_mode;
    logic       lane3_reset_sel;
    logic       quad_lane_enable;
  } cfg_t;
  // transfer mode word
  typedef struct packed {
    logic   tx_drive;
    lanes_t tx_lanes;
    lanes_t rx_lanes;
  } mode_t;
endpackage : flash_front_pkg

// *** test/flash_front_assertions.sv ***
// checker: lane float, lane timing, lane reuse and protection outputs
// assumes it is bound into flash_front and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_defs.svh"
module flash_front_chk
#(
  parameter int SECTOR_AW = 14
)(
  input wire logic                 mclk_i,
  input wire logic                 rst_i,
  input wire logic [7:0]           addr_i,
  input wire logic [31:0]          wdata_i,
  input wire logic                 we_i,
  input wire logic                 sclk_i,
  input wire logic                 cs_n_i,
  input wire logic                 reset_n_i,
  input wire logic [3:0]           lane_out_o,
  input wire logic [3:0]           lane_oe_o,
  input wire logic                 quad_lane_enable_o,
  input wire logic                 status_write_block_o,
  input wire logic                 prot_none_o,
  input wire logic [SECTOR_AW-1:0] prot_first_o,
  input wire logic [SECTOR_AW-1:0] prot_last_o
);
  // ====================
  // assertions
  // link flops clear asynchronously, so their levels are settled at any register edge
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  desel_float_a: assert property (cs_n_i |-> lane_oe_o == 4'h0)
    else $error("lanes driven while deselected");
  pin_reset_float_a: assert property (!reset_n_i |-> lane_oe_o == 4'h0)
    else $error("lanes driven during pin reset");
  fall_only_a: assert property (sclk_i && $past(sclk_i) && !cs_n_i && reset_n_i
    && $past(reset_n_i) |-> $stable(lane_out_o))
    else $error("lane output moved while clock high");
  upper_lanes_a: assert property (|lane_oe_o[3:2] |-> quad_lane_enable_o)
    else $error("upper lanes driven without quad enable");
  qe_copy_a: assert property (we_i && addr_i == `REG_CONFIG
    |-> ##2 quad_lane_enable_o == $past(wdata_i[0], 2))
    else $error("quad enable output not the written bit");
  wp_quad_a: assert property (quad_lane_enable_o && $past(quad_lane_enable_o)
    && $past(quad_lane_enable_o, 2) |-> !status_write_block_o)
    else $error("protect pin active while it is a data lane");
  prot_order_a: assert property (!prot_none_o |-> prot_first_o <= prot_last_o)
    else $error("protected range reversed");
  prot_whole_a: assert property (we_i && addr_i == `REG_CONFIG && wdata_i[8:4] == 5'h1e
    |-> ##[1:3] (prot_first_o == '0 && &prot_last_o && !prot_none_o))
    else $error("full block protect does not cover the array");
endmodule : flash_front_chk

bind flash_front flash_front_chk #(.SECTOR_AW(SECTOR_AW)) flash_front_chk_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .reset_n_i(reset_n_i), .lane_out_o(lane_out_o),
  .lane_oe_o(lane_oe_o), .quad_lane_enable_o(quad_lane_enable_o),
  .status_write_block_o(status_write_block_o), .prot_none_o(prot_none_o),
  .prot_first_o(prot_first_o), .prot_last_o(prot_last_o)
);
`default_nettype wire

// *** test/spi_host.sv ***
// host controller model: select, mode 0 serial clock, lane levels
// assumes tasks are entered at whole-ns times; its own edges fall on half-ns
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  input  wire logic [3:0] lane_out_i,
  input  wire logic [3:0] lane_oe_i,
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic [3:0]      lane_o
);
  logic [3:0] hv;
  // ====================
  // pins
  // device wins a lane while it drives; lanes 2 and 3 are pulled up
  assign lane_o = (lane_oe_i & lane_out_i) | (~lane_oe_i & hv);
  initial
  begin
    sclk_o = 1'b0;   // mode 0 idle low at both select edges
    cs_n_o = 1'b1;
    hv     = 4'hf;
  end
  // ====================
  // frames
  // clock stands still outside frames; long tail lets the select edge sync in
  task automatic sel(input logic on);
    #2.5 cs_n_o = ~on;   // select edge, falling when on is set and rising when it is clear
    #45.5;
  endtask : sel
  // one byte on w lanes, top lane first; four ignored clocks paused before clock pz
  task automatic xfer(input logic [7:0] d, input int w, input int pz, output logic [7:0] r);
    #2.5;
    for (int k = 0; k < 8 / w; k++)
    begin
      if (k == pz)
      begin
        hv[3] = 1'b0;   // pause with clock low, select kept low
        repeat (4)
        begin
          hv[0] = ~hv[0];
          #15 sclk_o = 1'b1;
          #15 sclk_o = 1'b0;
        end
        hv[3] = 1'b1;
      end
      for (int j = 0; j < w; j++)
        hv[j] = d[8 - w * (k + 1) + j];
      #15 sclk_o = 1'b1;
      r = {r[6:0], lane_o[1]};   // read bit taken on the rise
      #15 sclk_o = 1'b0;
    end
    hv = {2'b11, ~hv[1:0]};   // released lines do not keep their last value
    #2.5;
  endtask : xfer
endmodule : spi_host
`default_nettype wire

// *** test/tb_flash_front.sv ***
// self-checking bench for the flash pin front end
// assumes flash_front, its bound checker and spi_host are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_defs.svh"
module tb_flash_front;
  import flash_front_pkg::*;
  logic        mclk, rst, we, re, reset_n;
  logic [7:0]  addr, r;
  logic [31:0] wdata, rdata;
  logic        sclk, cs_n, wblk, pnone, busy, qeo;
  logic [3:0]  lane_in, lane_out, lane_oe;
  logic [13:0] pfirst, plast;
  int          error_cnt = 0, n_compared = 0, cyc = 0;

  // ====================
  // design and host
  flash_front flash_front_i (
    .mclk_i(mclk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata), .busy_i(busy), .sclk_i(sclk), .cs_n_i(cs_n), .reset_n_i(reset_n),
    .lane_in_i(lane_in), .lane_out_o(lane_out), .lane_oe_o(lane_oe),
    .quad_lane_enable_o(qeo), .status_write_block_o(wblk), .prot_none_o(pnone),
    .prot_first_o(pfirst), .prot_last_o(plast)
  );
  spi_host spi_host_i (
    .lane_out_i(lane_out), .lane_oe_i(lane_oe), .sclk_o(sclk), .cs_n_o(cs_n), .lane_o(lane_in)
  );
  // clock and hang guard; the run needs under a thousand cycles
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end

  // ====================
  // helpers
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_compared++;
    if ((got & m) !== (exp & m))
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got & m, exp & m);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge mclk);
    we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge mclk);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk);
    re <= 1'b0;
    #1 check(rdata, exp, m);
  endtask : rd
  task automatic frame(input logic [7:0] ins, input logic [7:0] d, input int w);
    spi_host_i.sel(1'b1);
    spi_host_i.xfer(ins, 1, -1, r);
    if (w > 0)
      spi_host_i.xfer(d, w, -1, r);
    spi_host_i.sel(1'b0);
    wt(8);
  endtask : frame
  task automatic prot(input logic [31:0] c, input logic [13:0] f, input logic [13:0] l);
    wr(`REG_CONFIG, c);
    wt(3);
    check({31'h0, pnone}, 32'h0, 32'h1);
    rd(`REG_PROT, {2'h0, l, 2'h0, f}, 32'h3fff3fff);
    check({2'h0, plast, 2'h0, pfirst}, {2'h0, l, 2'h0, f}, 32'h3fff3fff);
  endtask : prot

  // ====================
  // scenarios
  task automatic t_regs;
    rd(`REG_CONFIG, 32'h0, 32'hffffffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    wr(`REG_CONFIG, 32'hffffffff);
    rd(`REG_CONFIG, 32'h1ff, 32'hffffffff);
    prot(32'h1e0, 14'h0, 14'h3fff);
    prot(32'h28, 14'h0, 14'h0);
    prot(32'h20, 14'h3fff, 14'h3fff);
    prot(32'h30, 14'h0, 14'h3ffe);
    wr(`REG_CONFIG, 32'h0);
    wt(3);
    check({31'h0, pnone}, 32'h1, 32'h1);
  endtask : t_regs
  task automatic t_arm;
    spi_host_i.xfer(8'h81, 1, -1, r);
    spi_host_i.sel(1'b0);
    rd(`REG_STATUS, 32'h0, 32'h23);
    frame(8'h3c, 8'h0, 0);
    rd(`REG_STATUS, 32'h6, 32'h6);
    rd(`REG_RXDATA, 32'h3c, 32'hff);
  endtask : t_arm
  task automatic t_read;
    wr(`REG_MODE, 32'h10);
    wr(`REG_TXDATA, 32'ha5);
    spi_host_i.sel(1'b1);
    spi_host_i.xfer(8'h0b, 1, -1, r);
    spi_host_i.xfer(8'h00, 1, -1, r);
    check({24'h0, r}, 32'ha5, 32'hff);
    check({28'h0, lane_oe}, 32'h2, 32'hf);
    spi_host_i.sel(1'b0);
    check({28'h0, lane_oe}, 32'h0, 32'hf);
    wt(1);
    busy <= 1'b1;
    rd(`REG_STATUS, 32'h20, 32'h20);
    wt(1);
    busy <= 1'b0;
    wr(`REG_MODE, 32'h0);
    rd(`REG_RXDATA, 32'h0, 32'hff);
  endtask : t_read
  task automatic t_pause;
    spi_host_i.sel(1'b1);
    spi_host_i.xfer(8'h96, 1, 4, r);
    spi_host_i.sel(1'b0);
    wt(8);
    rd(`REG_RXDATA, 32'h96, 32'hff);
  endtask : t_pause
  task automatic t_lanes;
    wr(`REG_MODE, 32'h1);
    frame(8'h6b, 8'hd2, 2);
    rd(`REG_RXDATA, 32'hd2, 32'hff);
    wr(`REG_MODE, 32'h2);
    frame(8'heb, 8'hda, 4);
    rd(`REG_STATUS, 32'h10, 32'h10);
    wr(`REG_STATUS, 32'h18);
    wr(`REG_CONFIG, 32'h3);
    frame(8'heb, 8'h37, 4);
    rd(`REG_RXDATA, 32'h37, 32'hff);
    rd(`REG_STATUS, 32'h0, 32'h10);
    check({31'h0, qeo}, 32'h1, 32'h1);
    // quad transmit: all four lanes driven with the top nibble of the held byte
    wr(`REG_MODE, 32'h18);
    spi_host_i.sel(1'b1);
    spi_host_i.xfer(8'heb, 1, -1, r);
    check({24'h0, lane_oe, lane_out}, 32'hfa, 32'hff);
    spi_host_i.sel(1'b0);
    wr(`REG_CONFIG, 32'h0);
    wr(`REG_MODE, 32'h0);
  endtask : t_lanes
  task automatic t_wp;
    wr(`REG_CONFIG, 32'h4);
    spi_host_i.hv[2] <= 1'b0;
    wt(6);
    check({31'h0, wblk}, 32'h1, 32'h1);
    rd(`REG_STATUS, 32'h80, 32'h80);
    wr(`REG_CONFIG, 32'h5);
    wt(4);
    check({31'h0, wblk}, 32'h0, 32'h1);
    spi_host_i.hv[2] <= 1'b1;
    wr(`REG_CONFIG, 32'h0);
  endtask : t_wp
  task automatic t_rst;
    spi_host_i.sel(1'b1);
    spi_host_i.xfer(8'h11, 1, -1, r);
    wt(1);
    reset_n <= 1'b0;
    wt(4);
    reset_n <= 1'b1;
    wt(6);
    spi_host_i.xfer(8'h22, 1, -1, r);
    spi_host_i.sel(1'b0);
    wt(8);
    rd(`REG_STATUS, 32'h0, 32'h2);
    rd(`REG_RXDATA, 32'h11, 32'hff);
    wr(`REG_CONFIG, 32'h2);
    spi_host_i.sel(1'b1);
    spi_host_i.xfer(8'h44, 1, 4, r);
    spi_host_i.sel(1'b0);
    wt(8);
    rd(`REG_STATUS, 32'h0, 32'h2);
    wr(`REG_CONFIG, 32'h0);
  endtask : t_rst

  // ====================
  // main sequence: select falls inside reset, so it is not a fresh edge
  initial
  begin
    {mclk, rst, we, re, reset_n, busy} = 6'b010000;
    addr = 8'h00;
    wdata = 32'h0;
    wt(5);
    // pin reset clears the link flops that rst_i leaves alone
    reset_n <= 1'b1;
    spi_host_i.sel(1'b1);
    wt(5);
    rst <= 1'b0;
    t_regs();
    t_arm();
    t_read();
    t_pause();
    t_lanes();
    t_wp();
    t_rst();
    finish_test();
  end
endmodule : tb_flash_front
`default_nettype wire
